// [hw/trp_pkg.sv]
// Purpose: Shared constants and types of the area trigger control core.
// Assumes: One 250 MHz clock; Avalon-MM register bus with byte addresses.
// Notes:   Rate is held as a period in clock cycles.

package trp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned RATE_RESET_HZ = 8;
    localparam logic [31:0] PERIOD_RESET  = 32'(CLK_HZ / RATE_RESET_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // Structure
    localparam int NPROC       = 2;
    localparam int NSHAPER     = 4;
    localparam int NPIN        = 8;
    localparam int QUEUE_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Per-process offsets, base is process times 0x80
    localparam logic [6:0] OFF_CTRL     = 7'h00;
    localparam logic [6:0] OFF_PERIOD   = 7'h04;
    localparam logic [6:0] OFF_SOFT     = 7'h08;
    localparam logic [6:0] OFF_STAT     = 7'h0c;
    localparam logic [2:0] SHP_BASE_IDX = 3'h1;   // Shaper k at 0x10 + 0x10*k
    localparam logic [1:0] SHP_DELAY    = 2'h0;
    localparam logic [1:0] SHP_WIDTH    = 2'h1;
    localparam logic [1:0] SHP_DOWN     = 2'h2;

    // Global offsets
    localparam logic [9:0] ADDR_IRQ_STAT = 10'h100;
    localparam logic [9:0] ADDR_IRQ_CLR  = 10'h104;
    localparam logic [9:0] ADDR_IRQ_EN   = 10'h108;
    localparam logic [9:0] ADDR_SIM_PER  = 10'h10c;
    localparam logic [9:0] ADDR_SIM_MODE = 10'h110;

    ////////////////////////////////////////////////////////////////////////////
    // Fields and encodings
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_RUN_LSB = 2;
    localparam int CTRL_QEN_BIT = 4;
    localparam int CTRL_PIN_LSB = 5;
    localparam int IRQ_OVR_LSB  = 0;
    localparam int IRQ_ISS_LSB  = 2;
    localparam int IRQ_W        = 4;

    localparam logic [1:0] SRC_GEN  = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_SOFT = 2'h2;
    localparam logic [1:0] SRC_SYNC = 2'h3;

    localparam logic [1:0] RUN_ACTIVE    = 2'h0;
    localparam logic [1:0] RUN_GRACEFUL  = 2'h1;
    localparam logic [1:0] RUN_IMMEDIATE = 2'h2;

    // Reset values
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0004;
    localparam logic [31:0] SIM_PERIOD_RESET = 32'h0000_0001;
    localparam logic [15:0] DELAY_RESET      = 16'h0000;
    localparam logic [15:0] WIDTH_RESET      = 16'h0001;
    localparam logic [15:0] DOWN_RESET       = 16'h0001;

    // Pulse shaper states
    typedef enum logic [2:0] {
        SHP_IDLE = 3'b001,
        SHP_WAIT = 3'b010,
        SHP_HIGH = 3'b100
    } trp_shp_state_t;

endpackage

// [hw/trp_pacer.sv]
// Purpose: Rate pacer, ready once a full period has passed since the last fire.
// Assumes: period_i of zero or one means no limit.
// Notes:   Counter saturates, so long idle gaps never wrap.

module trp_pacer (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clear_i,
    input  wire logic        fire_i,
    input  wire logic [31:0] period_i,
    output logic             ready_o
);

    logic [31:0] cnt;

    // Cycles since last fire; clear makes it ready at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 32'hffff_ffff;
        end else if (clear_i) begin
            cnt <= 32'hffff_ffff;
        end else if (fire_i) begin
            cnt <= 32'h0000_0000;
        end else if (cnt != 32'hffff_ffff) begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    // Interval shorter than the period is an overrun
    assign ready_o = ({1'b0, cnt} + 33'h0_0000_0001) >= {1'b0, period_i};

endmodule

// [hw/trp_shaper.sv]
// Purpose: Pulse shaper: downscale, delay, then width high.
// Assumes: Triggers arriving while busy are ignored.
// Notes:   Abort drops any pulse in progress at once.

module trp_shaper (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        abort_i,
    input  wire logic        trig_i,
    input  wire logic [15:0] delay_i,
    input  wire logic [15:0] width_i,
    input  wire logic [15:0] down_i,
    output logic             pulse_o
);

    trp_pkg::trp_shp_state_t state;
    logic [15:0]             cnt;
    logic [15:0]             dcnt;

    // Downscale counter, every down_i-th trigger starts a pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dcnt <= 16'h0000;
        end else if (abort_i) begin
            dcnt <= 16'h0000;
        end else if (trig_i && state == trp_pkg::SHP_IDLE) begin
            dcnt <= ((dcnt + 16'h0001) >= down_i) ? 16'h0000 : dcnt + 16'h0001;
        end
    end

    // Delay then high phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= trp_pkg::SHP_IDLE;
            cnt   <= 16'h0000;
        end else if (abort_i) begin
            state <= trp_pkg::SHP_IDLE;
            cnt   <= 16'h0000;
        end else begin
            case (state)
                trp_pkg::SHP_IDLE: begin
                    if (trig_i && (dcnt + 16'h0001) >= down_i) begin
                        state <= trp_pkg::SHP_WAIT;
                        cnt   <= delay_i;
                    end
                end
                trp_pkg::SHP_WAIT: begin
                    if (cnt == 16'h0000) begin
                        state <= trp_pkg::SHP_HIGH;
                        cnt   <= width_i;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                trp_pkg::SHP_HIGH: begin
                    if (cnt <= 16'h0001) begin
                        state <= trp_pkg::SHP_IDLE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= trp_pkg::SHP_IDLE;
                end
            endcase
        end
    end

    assign pulse_o = (state == trp_pkg::SHP_HIGH);

endmodule

// [hw/trp_area_trigger_ctrl.sv]
// Purpose: Two-process area trigger control with Avalon-MM registers.
// Assumes: Trigger pins are asynchronous; one 250 MHz clock.
// Notes:   Rate is a period in cycles, clamped to shaper delay plus width plus one.
//
// Overview of operation
// - Active state queues, paces and shapes pulses
// - Graceful halt drops inputs, stops generator
// - Graceful halt finishes queued and shaping pulses
// - Immediate halt stops whole path at once
// - Restart to active clears queue and sequencer
// - Generator fires at the programmed rate
// - Too-fast inputs are dropped without queue
// - Input dropped while running raises an event flag
// - Queue stores excess, releases at rate
// - Rate also caps sequencer output pulses
// - Shaper delay and width bound the period
// - Generator mode ignores pins and software
// - Synchronized source only process 1, from 0
// - Each software write makes one input pulse

module trp_area_trigger_ctrl #(
    parameter logic [31:0] PERIOD_RESET_CYCLES = trp_pkg::PERIOD_RESET
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [9:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic [31:0]                   avs_readdata_o,
    output logic                          avs_waitrequest_o,
    input  wire logic [trp_pkg::NPIN-1:0] trig_pin_i,
    output logic [7:0]                    trig_out_o,
    output logic                          irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register storage, per-process and per-shaper sets plus global registers

    logic [31:0] ctrl       [trp_pkg::NPROC];
    logic [31:0] period     [trp_pkg::NPROC];
    logic [15:0] shp_delay  [8];
    logic [15:0] shp_width  [8];
    logic [15:0] shp_down   [8];
    logic [trp_pkg::IRQ_W-1:0] irq_stat;
    logic [trp_pkg::IRQ_W-1:0] irq_en;
    logic [31:0] sim_period;
    logic        sim_mode;
    logic [31:0] readdata;
    logic        ack;

    // Per-process state exported for readback
    logic [4:0]  qlvl       [trp_pkg::NPROC];
    logic [1:0]  ready_v;
    logic [31:0] eff_period [trp_pkg::NPROC];
    logic [1:0]  soft_wr;
    logic [1:0]  ovr_evt;
    logic [1:0]  iss_evt;

    // Address decode
    logic        wr_fire;
    logic        is_glob;
    logic        proc_sel;
    logic [6:0]  off;
    logic [2:0]  shp_row;
    logic        is_shp;
    logic [2:0]  shp_idx;

    assign is_glob  = avs_address_i[8];
    assign proc_sel = avs_address_i[7];
    assign off      = avs_address_i[6:0];
    assign shp_row  = off[6:4] - trp_pkg::SHP_BASE_IDX;
    assign is_shp   = !is_glob && off[6:4] >= trp_pkg::SHP_BASE_IDX && shp_row < 3'h4;
    assign shp_idx  = {proc_sel, shp_row[1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Avalon handshake: one wait cycle, answer at the second edge

    assign wr_fire           = avs_write_i && ack;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign avs_readdata_o    = readdata;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i || avs_write_i) && !ack;
        end
    end

    // Read mux captured as the wait cycle ends; unmapped reads give zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            readdata <= 32'h0000_0000;
            if (is_glob) begin
                case (avs_address_i)
                    trp_pkg::ADDR_IRQ_STAT: readdata <= 32'(irq_stat);
                    trp_pkg::ADDR_IRQ_EN:   readdata <= 32'(irq_en);
                    trp_pkg::ADDR_SIM_PER:  readdata <= sim_period;
                    trp_pkg::ADDR_SIM_MODE: readdata <= 32'(sim_mode);
                    default:                readdata <= 32'h0000_0000;
                endcase
            end else if (is_shp) begin
                case (off[3:2])
                    trp_pkg::SHP_DELAY: readdata <= 32'(shp_delay[shp_idx]);
                    trp_pkg::SHP_WIDTH: readdata <= 32'(shp_width[shp_idx]);
                    trp_pkg::SHP_DOWN:  readdata <= 32'(shp_down[shp_idx]);
                    default:            readdata <= 32'h0000_0000;
                endcase
            end else begin
                case (off)
                    trp_pkg::OFF_CTRL:   readdata <= ctrl[proc_sel];
                    trp_pkg::OFF_PERIOD: readdata <= period[proc_sel];
                    trp_pkg::OFF_STAT:   readdata <= {eff_period[proc_sel][23:0], 2'h0,
                                                      ready_v[proc_sel], qlvl[proc_sel]};
                    default:             readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    // Process settings kept apart per process
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < trp_pkg::NPROC; p++) begin
                ctrl[p]   <= trp_pkg::CTRL_RESET;
                period[p] <= PERIOD_RESET_CYCLES;
            end
        end else if (wr_fire && !is_glob && !is_shp) begin
            if (off == trp_pkg::OFF_CTRL) begin
                // Synchronized source refused on process 0, old value kept
                if (proc_sel || avs_writedata_i[1:0] != trp_pkg::SRC_SYNC) begin
                    ctrl[proc_sel] <= be_merge(ctrl[proc_sel], avs_writedata_i, avs_byteenable_i);
                end
            end
            if (off == trp_pkg::OFF_PERIOD) begin
                period[proc_sel] <= be_merge(period[proc_sel], avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // Shaper settings
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < 8; k++) begin
                shp_delay[k] <= trp_pkg::DELAY_RESET;
                shp_width[k] <= trp_pkg::WIDTH_RESET;
                shp_down[k]  <= trp_pkg::DOWN_RESET;
            end
        end else if (wr_fire && is_shp) begin
            case (off[3:2])
                trp_pkg::SHP_DELAY: shp_delay[shp_idx] <= avs_writedata_i[15:0];
                trp_pkg::SHP_WIDTH: shp_width[shp_idx] <= avs_writedata_i[15:0];
                trp_pkg::SHP_DOWN:  shp_down[shp_idx]  <= avs_writedata_i[15:0];
                default: begin
                end
            endcase
        end
    end

    // Global settings
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en     <= '0;
            sim_period <= trp_pkg::SIM_PERIOD_RESET;
            sim_mode   <= 1'b0;
        end else if (wr_fire && is_glob) begin
            if (avs_address_i == trp_pkg::ADDR_IRQ_EN) begin
                irq_en <= avs_writedata_i[trp_pkg::IRQ_W-1:0];
            end
            if (avs_address_i == trp_pkg::ADDR_SIM_PER) begin
                sim_period <= be_merge(sim_period, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == trp_pkg::ADDR_SIM_MODE) begin
                sim_mode <= avs_writedata_i[0];
            end
        end
    end

    // One pulse per software trigger write
    assign soft_wr[0] = wr_fire && !is_glob && !proc_sel && off == trp_pkg::OFF_SOFT;
    assign soft_wr[1] = wr_fire && !is_glob && proc_sel && off == trp_pkg::OFF_SOFT;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events, set wins over a clear in the same cycle

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_fire && avs_address_i == trp_pkg::ADDR_IRQ_CLR) ?
                                      avs_writedata_i[trp_pkg::IRQ_W-1:0] : '0))
                        | {iss_evt, ovr_evt};
        end
    end

    assign irq_o = |(irq_stat & irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // Pin input: three flops, change taken once the last two agree

    logic [trp_pkg::NPIN-1:0] pin_s1;
    logic [trp_pkg::NPIN-1:0] pin_s2;
    logic [trp_pkg::NPIN-1:0] pin_s3;
    logic [trp_pkg::NPIN-1:0] pin_lvl;
    logic [trp_pkg::NPIN-1:0] pin_prev;
    logic [trp_pkg::NPIN-1:0] pin_rise;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_s3   <= '0;
            pin_lvl  <= '0;
            pin_prev <= '0;
        end else begin
            pin_s1   <= trig_pin_i;
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_lvl  <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
            pin_prev <= pin_lvl;
        end
    end

    assign pin_rise = pin_lvl & ~pin_prev;

    // Process 0 output edge feeds the synchronized source
    logic sync_prev;
    logic sync_rise;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= trig_out_o[0];
        end
    end

    assign sync_rise = trig_out_o[0] && !sync_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger path per process

    for (genvar p = 0; p < trp_pkg::NPROC; p++) begin : g_proc
        logic [1:0]  src;
        logic [1:0]  run;
        logic        qen;
        logic [2:0]  pin;
        logic [1:0]  prev_run;
        logic        active;
        logic        immed;
        logic        restart;
        logic        in_pulse;
        logic        accept;
        logic        gen_fire;
        logic        direct;
        logic        q_push;
        logic        q_pop;
        logic        fire;
        logic [31:0] shp_min;

        assign src    = ctrl[p][trp_pkg::CTRL_SRC_LSB +: 2];
        assign run    = ctrl[p][trp_pkg::CTRL_RUN_LSB +: 2];
        assign qen    = ctrl[p][trp_pkg::CTRL_QEN_BIT];
        assign pin    = ctrl[p][trp_pkg::CTRL_PIN_LSB +: 3];
        assign active = (run == trp_pkg::RUN_ACTIVE);
        assign immed  = (run != trp_pkg::RUN_ACTIVE) && (run != trp_pkg::RUN_GRACEFUL);

        // Leaving a halt: queue and sequencer cleared first
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                prev_run <= trp_pkg::RUN_GRACEFUL;
            end else begin
                prev_run <= run;
            end
        end

        assign restart = active && (prev_run != trp_pkg::RUN_ACTIVE);

        // Period never shorter than delay plus width plus one of any shaper, nor than simulator rate
        always_comb begin
            shp_min = 32'h0000_0000;
            for (int k = 0; k < trp_pkg::NSHAPER; k++) begin
                shp_min = max32(shp_min, 32'(shp_delay[p*4+k]) + 32'(shp_width[p*4+k]) + 32'h1);
            end
        end

        assign eff_period[p] = max32(max32(period[p], shp_min), sim_mode ? sim_period : 32'h0);

        // Source select; generator mode listens to nothing outside
        always_comb begin
            case (src)
                trp_pkg::SRC_EXT:  in_pulse = pin_rise[pin];
                trp_pkg::SRC_SOFT: in_pulse = soft_wr[p];
                trp_pkg::SRC_SYNC: in_pulse = (p == 1) ? sync_rise : 1'b0;
                default:           in_pulse = 1'b0;
            endcase
        end

        // Only the running state takes new pulses
        assign accept   = active && !restart && in_pulse;
        assign gen_fire = active && !restart && src == trp_pkg::SRC_GEN && ready_v[p];
        assign direct   = accept && ready_v[p] && qlvl[p] == 5'h00;
        assign q_push   = accept && qen && !direct && qlvl[p] < 5'(trp_pkg::QUEUE_DEPTH);
        assign q_pop    = qlvl[p] != 5'h00 && ready_v[p] && !immed && !restart;
        assign fire     = gen_fire || direct || q_pop;
        assign ovr_evt[p] = accept && !direct && !q_push;
        assign iss_evt[p] = fire;

        // Queue fill level, emptied on restart or immediate halt
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                qlvl[p] <= 5'h00;
            end else if (restart || immed) begin
                qlvl[p] <= 5'h00;
            end else begin
                qlvl[p] <= qlvl[p] + 5'(q_push) - 5'(q_pop);
            end
        end

        // Sequencer pacing shared by generator, direct path and queue
        trp_pacer u_pacer (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .clear_i  (restart || immed),
            .fire_i   (fire),
            .period_i (eff_period[p]),
            .ready_o  (ready_v[p])
        );

        // Shapers keep running through a graceful halt
        for (genvar k = 0; k < trp_pkg::NSHAPER; k++) begin : g_shp
            trp_shaper u_shaper (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .abort_i (immed),
                .trig_i  (fire),
                .delay_i (shp_delay[p*4+k]),
                .width_i (shp_width[p*4+k]),
                .down_i  (shp_down[p*4+k]),
                .pulse_o (trig_out_o[p*4+k])
            );
        end
    end

endmodule

// [testbench/trp_assertions.sv]
// Purpose: Port checks of the trigger core
// Assumes: Master holds a request until ack
// Notes:   Bound to the top module below
module trp_assertions (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [9:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [7:0]  trig_out_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Acked immediate halt of process 0
    sequence halt_req;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h000 && avs_writedata_i[3:2] == 2'h2;
    endsequence
    sequence quiet0;
        (trig_out_o[3:0] == 4'h0) [*4];
    endsequence
    ////////////////////////
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("no wait");
    ack_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("late ack");
    ack_once_a: assert property ((avs_read_i || avs_write_i) && !avs_waitrequest_o |=> !(avs_read_i || avs_write_i)
        || avs_waitrequest_o) else $error("double ack");
    clr_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == trp_pkg::ADDR_IRQ_CLR
        |-> avs_readdata_o == 32'h0) else $error("clear reg read");
    irq_hold_a: assert property (irq_o && !(avs_write_i && !avs_waitrequest_o) |=> irq_o) else $error("irq lost");
    halt_stop_a: assert property (halt_req |-> ##3 quiet0) else $error("halt late");
    reset_out_a: assert property ($rose(rst_n_i) |-> trig_out_o == 8'h00) else $error("output after reset");
    reset_irq_a: assert property ($rose(rst_n_i) |-> !irq_o) else $error("irq after reset");
endmodule
bind trp_area_trigger_ctrl trp_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .trig_out_o(trig_out_o), .irq_o(irq_o));

// [testbench/trp_pin_src.sv]
// Purpose: External trigger source on pin 0
// Assumes: Pulses outlast the input filter
// Notes:   Pin idles low between pulses
module trp_pin_src (
    input wire logic       clk_i,
    output logic     [7:0] trig_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial trig_pin_o = 8'h00;
    // Burst of n pulses, one every gap+1 cycles
    task automatic burst(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i);
            trig_pin_o <= 8'h01;
            repeat (8) @(posedge clk_i);
            trig_pin_o <= 8'h00;
            repeat (gap - 8) @(posedge clk_i);
        end
    endtask
endmodule

// [testbench/trp_area_trigger_ctrl_tb.sv]
// Purpose: Register-driven test of the trigger core
// Assumes: Period parameter shortened to 100
// Notes:   Counts pulses of process 0 shaper 0
module trp_area_trigger_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PER = 32'h64;
    logic clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, irq_o, prev = 0;
    logic [9:0]  avs_address_i = 10'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d;
    logic [7:0]  trig_pin_i, trig_out_o;
    int          checks = 0, miscompares = 0, rises = 0, cyc = 0, r0;
    trp_area_trigger_ctrl #(.PERIOD_RESET_CYCLES(PER)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .trig_pin_i(trig_pin_i), .trig_out_o(trig_out_o), .irq_o(irq_o));
    trp_pin_src src (.clk_i(clk_i), .trig_pin_o(trig_pin_i));
    initial forever #2 clk_i = ~clk_i;
    ////////////////////////
    // Edge counter and hang guard
    always @(posedge clk_i) begin
        prev <= trig_out_o[0];
        if (trig_out_o[0] === 1'b1 && prev === 1'b0) rises <= rises + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycle: hold until waitrequest is seen low at an edge
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic pulses(input int n, input logic [31:0] exp);
        int c0;
        c0 = rises;
        repeat (n) @(posedge clk_i);
        chk("pulses", 32'(rises - c0), exp);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        xfer(0, 10'h000, 0); chk("ctrl", d, trp_pkg::CTRL_RESET);
        xfer(0, 10'h004, 0); chk("period", d, PER);
        xfer(0, 10'h1fc, 0); chk("unmapped", d, 32'h0);
        // Generator with pins toggling beside it
        xfer(1, 10'h080, 32'h3);
        xfer(1, 10'h000, 32'h0);
        fork src.burst(10, 60); pulses(1000, 10); join
        xfer(0, trp_pkg::ADDR_IRQ_STAT, 0); chk("sync issue", {28'h0, d[3:0]}, 32'hc);
        xfer(1, 10'h000, 32'h8);
        // A pulse cut by the halt may still show for a cycle
        repeat (4) @(posedge clk_i);
        pulses(300, 0);
        // External, no queue: every other pulse is too close
        xfer(1, 10'h000, 32'h1);
        xfer(1, 10'h004, PER);
        repeat (200) @(posedge clk_i);
        fork src.burst(10, 60); pulses(1300, 5); join
        xfer(0, trp_pkg::ADDR_IRQ_STAT, 0); chk("overrun", {31'h0, d[0]}, 32'h1);
        @(negedge clk_i); chk("irq masked", {31'h0, irq_o}, 32'h0);
        xfer(1, trp_pkg::ADDR_IRQ_EN, 32'h1);
        @(negedge clk_i); chk("irq", {31'h0, irq_o}, 32'h1);
        xfer(1, trp_pkg::ADDR_IRQ_CLR, 32'h1);
        @(negedge clk_i); chk("irq clr", {31'h0, irq_o}, 32'h0);
        xfer(0, trp_pkg::ADDR_IRQ_CLR, 0); chk("clr read", d, 32'h0);
        // Queue keeps every pulse, no overrun
        xfer(1, 10'h000, 32'h11);
        repeat (200) @(posedge clk_i);
        fork src.burst(10, 60); pulses(1300, 10); join
        xfer(0, trp_pkg::ADDR_IRQ_STAT, 0); chk("no overrun", {31'h0, d[0]}, 32'h0);
        xfer(1, 10'h000, 32'h3);
        xfer(0, 10'h000, 0); chk("sync on proc 0", d, 32'h11);
        // Software pulses, then graceful halt drops them
        xfer(1, 10'h000, 32'h2);
        repeat (200) @(posedge clk_i);
        r0 = rises;
        for (int i = 0; i < 3; i++) begin
            xfer(1, 10'h008, 32'h1);
            repeat (150) @(posedge clk_i);
        end
        chk("soft", 32'(rises - r0), 32'h3);
        xfer(1, 10'h000, 32'h6);
        xfer(1, 10'h008, 32'h1);
        pulses(300, 0);
        complete_run();
    end
endmodule
